/* File: logic/pao_port.sv */
// Purpose: digital side of an 8-bit two-step subranging converter
// Assumes: coarse/fine comparator results arrive synchronous to i_clk
// Notes:   pins are split into value and enable; enable low means driving
`timescale 1ns/1ns
`default_nettype none
`include "pao_cfg.svh"
// How it works
// R1 - each code reaches the outputs four clock cycles after its sample
// R2 - one new sample taken and one code delivered every clock cycle
// R3 - results are unsigned codes, one of 256 values
// R4 - coarse and fine results merged with error correction into 8 bits
// R5 - input tracked while clock high, held after each falling edge
// R6 - drive enable low drives data pins, high floats them
// R7 - drive enable touches only drivers; pipeline keeps advancing
// R8 - power-down stops conversion and floats data regardless of enable
// R9 - after power-down ends, four cycles pass before codes are valid
// R10 - the controller never leaves the drive enable floating
// R11 - coarse bank picks subrange first, fine bank resolves next period
// R12 - dynamic references settle 50 ns before, hold 10 ns after aperture
// R13 - capture logic drops alternate samples when references change each second cycle
// R14 - sample to output delay is constant at the pipeline latency
// R15 - power-down is a single clock-synchronous input
module pao_port
   import pao_pkg::*;
#(
   parameter int LATENCY = `PAO_LATENCY,
   parameter int DEPTH   = `PAO_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_srst,
   // comparator results from the analog front end
   input  wire logic [`PAO_FINE_W-1:0] i_coarse,
   input  wire logic [`PAO_FINE_W:0]   i_fine,
   // control pins
   input  wire logic                   i_drive_en_n,
   input  wire logic                   i_power_down,
   // data pins
   output logic      [`PAO_CODE_W-1:0] o_data,
   output logic      [`PAO_CODE_W-1:0] o_data_oe_n,
   output logic                        o_data_valid
);
   if (LATENCY != 4) begin : g_bad_latency
      $error("front end timing fixes the latency at four");
   end
   if (DEPTH < LATENCY) begin : g_bad_depth
      $error("buffer too shallow");
   end

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [1:0] oe_sync_q, pd_sync_q;
   logic       drive_n, pdown;
   always_ff @(posedge i_clk) begin
      oe_sync_q <= {oe_sync_q[0], i_drive_en_n};
      pd_sync_q <= {pd_sync_q[0], i_power_down}; // R15
   end
   assign drive_n = oe_sync_q[1];
   assign pdown   = pd_sync_q[1];

   // ****************************************
   // front end: sample, coarse, fine stages
   // ****************************************
   function automatic pao_code_t merge(input logic [`PAO_FINE_W-1:0] c,
                                       input logic [`PAO_FINE_W:0] f);
      logic [`PAO_CODE_W:0] sum;
      sum = {1'b0, c, {`PAO_FINE_W{1'b0}}} + {{`PAO_FINE_W{1'b0}}, f}; // R4
      merge = sum[`PAO_CODE_W] ? pao_code_t'(`PAO_CODES - 1) : sum[`PAO_CODE_W-1:0]; // R3
   endfunction

   // held value captured on the falling edge, as the hold follows it
   logic [`PAO_FINE_W-1:0] coarse_hold_q;
   always_ff @(negedge i_clk) begin
      coarse_hold_q <= i_coarse; // R5
   end

   logic [`PAO_FINE_W-1:0] crs_q, crs_d;
   logic                   crs_v_q, crs_v_d, mrg_v_q, mrg_v_d;
   pao_code_t              mrg_q, mrg_d;
   always_comb begin
      crs_d   = coarse_hold_q; // R11
      crs_v_d = !pdown; // R8
      mrg_d   = merge(crs_q, i_fine); // R11
      mrg_v_d = crs_v_q && !pdown;
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         crs_q   <= '0;
         crs_v_q <= 1'b0;
         mrg_q   <= `PAO_RST_CODE;
         mrg_v_q <= 1'b0;
      end else begin
         crs_q   <= crs_d; // R2
         crs_v_q <= crs_v_d;
         mrg_q   <= mrg_d;
         mrg_v_q <= mrg_v_d;
      end
   end

   // ****************************************
   // buffer and output stage
   // ****************************************
   logic      f_in_ready, f_out_valid, f_pop;
   pao_code_t f_out_data;
   assign f_pop = 1'b1; // one word leaves each cycle: fixed latency
   pao_fifo #(.WIDTH(`PAO_CODE_W), .DEPTH(DEPTH)) u_fifo (
      .i_clk       (i_clk),
      .i_srst      (i_srst || pdown),
      .i_in_valid  (mrg_v_q),
      .i_in_data   (mrg_q),
      .o_in_ready  (f_in_ready),
      .o_out_valid (f_out_valid),
      .o_out_data  (f_out_data),
      .i_out_ready (f_pop)
   );

   pao_state_e st_q, st_d;
   logic [2:0] warm_q, warm_d;
   pao_code_t  data_d;
   logic       oe_d, valid_d;
   always_comb begin
      st_d    = st_q;
      warm_d  = warm_q;
      unique case (st_q)
         PAO_OFF: begin
            warm_d = '0;
            if (!pdown) st_d = PAO_WARM;
         end
         PAO_WARM: begin
            warm_d = warm_q + 3'd1;
            if (pdown) st_d = PAO_OFF;
            else if (warm_q == 3'(`PAO_RESUME_CYC - 2)) st_d = PAO_RUN; // R9
         end
         PAO_RUN: begin
            if (pdown) st_d = PAO_OFF; // R8
         end
      endcase
      data_d  = f_out_valid ? f_out_data : o_data; // R7
      valid_d = (st_q == PAO_RUN) && !pdown && f_out_valid && f_in_ready;
      oe_d    = drive_n || pdown || st_q == PAO_OFF; // R6 R8
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q         <= PAO_OFF;
         warm_q       <= '0;
         o_data       <= `PAO_RST_CODE;
         o_data_oe_n  <= '1;
         o_data_valid <= 1'b0;
      end else begin
         st_q         <= st_d;
         warm_q       <= warm_d;
         o_data       <= data_d; // R1 R14
         o_data_oe_n  <= {`PAO_CODE_W{oe_d}};
         o_data_valid <= valid_d;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_pd_floats : assert property (@(posedge i_clk) disable iff (i_srst) // R8
      pdown |=> o_data_oe_n == '1) else $error("outputs driven in power-down");
   a_oe_drives : assert property (@(posedge i_clk) disable iff (i_srst) // R6
      !drive_n && !pdown && st_q == PAO_RUN |=> o_data_oe_n == '0)
      else $error("outputs not driven while enabled");
   a_oe_floats : assert property (@(posedge i_clk) disable iff (i_srst) // R6
      drive_n |=> o_data_oe_n == '1) else $error("outputs driven while disabled");
   a_latency_fixed : assert property (@(posedge i_clk) disable iff (i_srst) // R1 R14
      (crs_v_q && !pdown) [*3] |=> o_data == $past(mrg_q, 2))
      else $error("code latency wrong");
   a_warm_time : assert property (@(posedge i_clk) disable iff (i_srst) // R9
      $fell(pdown) |-> (!o_data_valid) [*4]) else $error("valid too early after power-up");
   a_every_cycle : assert property (@(posedge i_clk) disable iff (i_srst) // R2
      o_data_valid && !pdown |=> o_data_valid || pdown)
      else $error("pipeline dropped a cycle");
   a_pipe_runs : assert property (@(posedge i_clk) disable iff (i_srst) // R7
      drive_n && !pdown && mrg_v_q |=> f_out_valid) else $error("pipeline stalled while floated");
   a_float_moves : assert property (@(posedge i_clk) disable iff (i_srst) // R7
      drive_n && !pdown && f_out_valid |=> o_data == $past(f_out_data))
      else $error("codes frozen while floated");
   a_merge_ok : assert property (@(posedge i_clk) disable iff (i_srst) // R4
      !$past(i_srst) |-> mrg_q == merge($past(crs_q), $past(i_fine)))
      else $error("merge mismatch");
   a_coarse_first : assert property (@(posedge i_clk) disable iff (i_srst) // R5 R11
      !$past(i_srst) |-> crs_q == $past(coarse_hold_q))
      else $error("coarse stage skipped");
   a_oe_uniform : assert property (@(posedge i_clk) disable iff (i_srst) // R6
      o_data_oe_n == '0 || o_data_oe_n == '1) else $error("data enables disagree");
   a_pd_no_valid : assert property (@(posedge i_clk) disable iff (i_srst) // R8
      pdown |=> !o_data_valid) else $error("code valid in power-down");
   a_pd_halts : assert property (@(posedge i_clk) disable iff (i_srst) // R8
      pdown |=> !crs_v_q && !mrg_v_q) else $error("conversion ran in power-down");
   a_pd_flush : assert property (@(posedge i_clk) disable iff (i_srst) // R8
      pdown |=> !f_out_valid) else $error("buffer kept codes in power-down");
   a_valid_run : assert property (@(posedge i_clk) disable iff (i_srst) // R9
      o_data_valid |-> $past(st_q == PAO_RUN))
      else $error("code valid outside run state");

   // ****************************************
   // resume watch: cycles since power-down last ended
   // ****************************************
   // kept apart from the state machine so the resume wait is checked on its own
   logic [2:0] up_cyc_q, up_cyc_d;
   always_comb begin
      up_cyc_d = up_cyc_q;
      if (pdown) begin
         up_cyc_d = '0;
      end else if (up_cyc_q != 3'h7) begin
         up_cyc_d = up_cyc_q + 3'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         up_cyc_q <= '0;
      end else begin
         up_cyc_q <= up_cyc_d;
      end
   end
   a_resume_gap : assert property (@(posedge i_clk) disable iff (i_srst) // R9
      o_data_valid |-> up_cyc_q >= 3'(`PAO_RESUME_CYC))
      else $error("code valid too soon after power-up");
endmodule
`default_nettype wire

/* File: logic/pao_cfg.svh */
// Purpose: constants for the pipelined converter output port
// Assumes: one 10 MHz clock
// Notes:   timing counts are in clock cycles, PAO_CLK_NS and PAO_PDD_NS in ns
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH
`define PAO_CODE_W      8
`define PAO_CODES       256
`define PAO_LATENCY     4
`define PAO_FIFO_DEPTH  32
`define PAO_CLK_NS      100
`define PAO_PDD_NS      200
`define PAO_RESUME_CYC  4
`define PAO_FINE_W      4
`define PAO_RST_CODE    8'h00
`endif

/* File: logic/pao_pkg.sv */
// Purpose: shared types for the converter output port
// Assumes: pao_cfg.svh holds the numbers
// Notes:   types only
`include "pao_cfg.svh"
package pao_pkg;
   typedef logic [`PAO_CODE_W-1:0] pao_code_t;
   typedef enum logic [2:0] {
      PAO_OFF  = 3'b001,
      PAO_WARM = 3'b010,
      PAO_RUN  = 3'b100
   } pao_state_e;
endpackage

/* File: logic/pao_fifo.sv */
// Purpose: sample buffer between the converter front end and the output stage
// Assumes: single clock, synchronous active-high reset
// Notes:   first-word-fall-through, honest full and empty
`timescale 1ns/1ns
`default_nettype none
module pao_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic      [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH)) || pop;
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem_q[rd_q];

   always_comb begin
      wr_d  = push ? wr_q + AW'(1) : wr_q;
      rd_d  = pop ? rd_q + AW'(1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   a_fifo_no_ovf : assert property (@(posedge i_clk) disable iff (i_srst)
      cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* File: tb/pao_capture.sv */
// Purpose: capture logic that latches codes from the data pins
// Assumes: one clock shared with the port
// Notes:   released pins show the inverse of the last driven level
`timescale 1ns/1ns
`default_nettype none
module pao_capture
   import pao_pkg::*;
(
   // clock and reset
   input  wire logic      i_clk,
   input  wire logic      i_srst,
   // data pins and mode
   input  wire logic      i_drop_alt,
   input  wire pao_code_t i_data,
   input  wire pao_code_t i_oe_n,
   input  wire logic      i_valid,
   // capture results
   output var pao_code_t  o_wire,
   output logic [15:0]    o_count
);
   pao_code_t drv_q;
   logic      phase_q;
   // a floating pin shows the inverse of its last level
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         o_wire[b] = i_oe_n[b] ? ~drv_q[b] : i_data[b];
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         drv_q <= 8'h00;
         phase_q <= 1'b0;
         o_count <= 16'h0000;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if (!i_oe_n[b]) begin
               drv_q[b] <= i_data[b];
            end
         end
         if (i_valid && i_oe_n == 8'h00) begin
            phase_q <= ~phase_q;
            if (!(i_drop_alt && phase_q)) begin
               o_count <= o_count + 16'h0001;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the converter output port
// Assumes: capture model beside the data pins
// Notes:   inputs change on the rising edge
`timescale 1ns/1ns
`default_nettype none
`include "pao_cfg.svh"
module tb
   import pao_pkg::*;
;
   logic clk = 1'b0, srst = 1'b1, en_n = 1'b0, pd = 1'b0, drop = 1'b0;
   logic [`PAO_FINE_W-1:0] crs = 4'h0;
   logic [`PAO_FINE_W:0]   fin = 5'h00;
   pao_code_t dat, oe_n, pins;
   logic vld;
   logic [15:0] cnt;
   int bad_count = 0;
   int checked = 0;
   always #50 clk = ~clk;
   pao_port pao_port_i (.i_clk(clk), .i_srst(srst), .i_coarse(crs), .i_fine(fin),
      .i_drive_en_n(en_n), .i_power_down(pd), .o_data(dat), .o_data_oe_n(oe_n),
      .o_data_valid(vld));
   pao_capture pao_capture_i (.i_clk(clk), .i_srst(srst), .i_drop_alt(drop), .i_data(dat),
      .i_oe_n(oe_n), .i_valid(vld), .o_wire(pins), .o_count(cnt));
   // ***************
   // helpers
   // ***************
   function automatic pao_code_t code(input int i);
      int v;
      v = (i % 16) * 16 + (i * 7) % 32;
      return (v > 255) ? 8'hFF : v[7:0];
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int i, input logic en, input logic p);
      @(posedge clk);
      crs <= i[3:0];
      fin <= 5'((i - 1) * 7);
      en_n <= en;
      pd <= p;
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ***************
   // scenarios
   // ***************
   task automatic t_reset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("rst data", {8'h00, dat}, 16'h0000);
      check("rst oe_n", {8'h00, oe_n}, 16'h00FF);
      check("rst valid", {15'h0000, vld}, 16'h0000);
      @(posedge clk);
      srst <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   task automatic t_stream;
      for (int i = 0; i < 40; i++) begin
         tick(i, 1'b0, 1'b0);
         if (i >= 4) begin
            check("code", {8'h00, dat}, {8'h00, code(i - 4)});
            check("valid", {15'h0000, vld}, 16'h0001);
            check("pins", {8'h00, pins}, {8'h00, code(i - 4)});
         end
      end
   endtask
   task automatic t_enable;
      for (int i = 0; i < 30; i++) begin
         tick(i, i >= 4 && i < 12, 1'b0);
         if (i >= 8 && i <= 12) check("oe_n off", {8'h00, oe_n}, 16'h00FF);
         if (i >= 8 && i <= 12) check("float code", {8'h00, dat}, {8'h00, code(i - 4)});
         if (i >= 8 && i <= 12) check("pins float", {8'h00, pins}, {8'h00, ~code(2)});
         if (i >= 16) check("code after float", {8'h00, dat}, {8'h00, code(i - 4)});
         if (i >= 16) check("oe_n on", {8'h00, oe_n}, 16'h0000);
      end
   endtask
   task automatic t_power;
      int v;
      v = -1;
      for (int i = 0; i < 50; i++) begin
         tick(i, 1'b0, i >= 2 && i < 10);
         if (i >= 7 && i <= 10) check("pd valid", {15'h0000, vld}, 16'h0000);
         if (i >= 7 && i <= 10) check("pd oe_n", {8'h00, oe_n}, 16'h00FF);
         if (i > 10 && v < 0 && vld === 1'b1) v = i;
         if (v > 0 && i > v) check("resumed code", {8'h00, dat}, {8'h00, code(i - 4)});
      end
      check("resume delay", {15'h0000, v >= 14}, 16'h0001);
   endtask
   task automatic t_alt;
      logic [15:0] n0;
      @(posedge clk);
      drop <= 1'b1;
      #1;
      n0 = cnt;
      for (int i = 0; i < 20; i++) tick(i, 1'b0, 1'b0);
      check("kept count", cnt - n0, 16'h000A);
      @(posedge clk);
      drop <= 1'b0;
   endtask
   initial begin
      t_reset();
      t_stream();
      t_enable();
      t_power();
      t_alt();
      t_reset();
      t_stream();
      final_report();
   end
endmodule
`default_nettype wire
